// ### trace_caps_defines.vh
// Constants for the trace capability identification bank
// Assumes inclusion by bare name from the design files
`ifndef TRACE_CAPS_DEFINES_VH
`define TRACE_CAPS_DEFINES_VH
// Shared selector fields of the system-register encoding
`define SEL_OP0            2'h2
`define SEL_OP1            3'h1
`define SEL_CRN            4'h0
`define SEL_OP2            3'h7
// Second coprocessor index per register
`define CRM_BASE_ARCH      4'hb
`define CRM_COMPARATOR     4'hc
`define CRM_RESOURCE       4'hd
// Exception levels
`define LEVEL0             2'h0
`define LEVEL1             2'h1
`define LEVEL2             2'h2
`define LEVEL3             2'h3
// Trap syndrome class
`define TRAP_CLASS         6'h18
// Result kinds
`define RES_OK             2'h0
`define RES_UNDEF          2'h1
`define RES_TRAP           2'h2
`define RES_NOMATCH        2'h3
// Field values of the first register
`define OVERFLOW_PREVENT   1'h0
`define STALL_PERMIT       1'h1
`define STALL_IMPL         1'h1
`define FIXED_SYNC         1'h0
`define FORCED_ERR         1'h1
`define LEVELS_FIELD       7'h7f
`define CORE_COUNT         5'h00
`define CORE_COUNT_HI      3'h0
`define CORE_COUNT_LO      2'h0
`define MIN_CYCLE_THR      12'h004
// Field values of the second register
`define VCTX_CMP           4'h1
`define CTX_CMP            4'h1
`define SINGLE_SHOT        4'h1
`define RSEL_PAIRS         4'h7
`define CORE_CMP_IN        4'h0
`define DATA_ADDR_CMP      1'h0
`define DATA_VAL_CMP       4'h0
`define ADDR_PAIRS         4'h4
// Field values of the third register
`define COUNTERS           3'h2
`define SEQ_STATES         3'h4
`define LOW_POWER_OVR      1'h1
`define BUS_TRIGGER        1'h1
`define TRACE_ID_WIDTH     6'h07
`define EXT_IN_SEL         3'h4
`define EXT_IN_COUNT       9'h0ff
`endif

// ### cap_word_builder.v
// Assembles the three constant capability words
// Assumes the defines header; output is purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "trace_caps_defines.vh"
module cap_word_builder (
  // Capability words
  output wire [63:0] base_arch_out,
  output wire [63:0] comparator_out,
  output wire [63:0] resource_out
);
  // Fixed words, independent of reset and writes
  assign base_arch_out = {32'h0, `OVERFLOW_PREVENT,
                          `CORE_COUNT_HI,
                          `STALL_PERMIT, `STALL_IMPL,
                          `FIXED_SYNC,
                          `FORCED_ERR,
                          1'b0, `LEVELS_FIELD,
                          2'b00, `CORE_COUNT_LO,
                          `MIN_CYCLE_THR};
  assign comparator_out = {32'h0, `VCTX_CMP, `CTX_CMP,
                           `SINGLE_SHOT,
                           `RSEL_PAIRS,
                           `CORE_CMP_IN, 3'b000,
                           `DATA_ADDR_CMP, `DATA_VAL_CMP,
                           `ADDR_PAIRS};
  assign resource_out = {33'h0, `COUNTERS,
                         `SEQ_STATES,
                         1'b0, `LOW_POWER_OVR,
                         `BUS_TRIGGER,
                         `TRACE_ID_WIDTH, 4'h0,
                         `EXT_IN_SEL,
                         `EXT_IN_COUNT};
endmodule
`default_nettype wire

// ### access_checker.v
// Decides undefined, trap or success for a capability read
// Assumes control bits are steady during the request
`timescale 1ns/1ps
`default_nettype none
`include "trace_caps_defines.vh"
module access_checker (
  // Context
  input  wire [1:0] level_in,
  input  wire       halted_in,
  input  wire       secure_debug_disabled_in,
  input  wire       level2_enabled_in,
  // Trap controls
  input  wire       level1_trace_trap_in,
  input  wire       level2_trace_trap_in,
  input  wire       level3_trace_trap_in,
  input  wire       fine_grained_trap_enable_in,
  input  wire       fine_grained_id_read_trap_in,
  // Verdict
  output reg  [1:0] result_out,
  output reg  [1:0] target_out
);
  wire dbg_lock;
  assign dbg_lock = halted_in & secure_debug_disabled_in;
  always @* begin
    result_out = `RES_OK;
    target_out = `LEVEL0;
    case (level_in)
      `LEVEL0: begin
        result_out = `RES_UNDEF;
      end
      `LEVEL1: begin
        if (dbg_lock && level3_trace_trap_in) begin
          result_out = `RES_UNDEF;
        end else if (level1_trace_trap_in) begin
          result_out = `RES_TRAP;
          target_out = `LEVEL1;
        end else if (level2_enabled_in && (level2_trace_trap_in ||
                     (fine_grained_trap_enable_in && fine_grained_id_read_trap_in))) begin
          result_out = `RES_TRAP;
          target_out = `LEVEL2;
        end else if (level3_trace_trap_in) begin
          result_out = `RES_TRAP;
          target_out = `LEVEL3;
        end
      end
      `LEVEL2: begin
        if (dbg_lock && level3_trace_trap_in) begin
          result_out = `RES_UNDEF;
        end else if (level2_trace_trap_in) begin
          result_out = `RES_TRAP;
          target_out = `LEVEL2;
        end else if (level3_trace_trap_in) begin
          result_out = `RES_TRAP;
          target_out = `LEVEL3;
        end
      end
      default: begin
        if (level3_trace_trap_in) begin
          result_out = `RES_TRAP;
          target_out = `LEVEL3;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// ### trace_unit_capability_ids.v
// Capability identification bank read by system-register reads
// Assumes one read request per cycle, context inputs synchronous
// Notes on behaviour
// - Overflow-prevention bit 31 reads zero
// - Stall permitted and implemented bits read one
// - Fixed-sync-period bit 25 reads zero
// - Forced error tracing bit 24 reads one
// - Level bits 22:16 one, bit 23 zero
// - Split core-count field reads zero
// - Minimum cycle threshold nonzero with cycle counting
// - One virtual and one context comparator
// - One single-shot comparator control
// - Resource selector field holds seven
// - No core comparator inputs, reserved zero
// - No data address or value comparison
// - Four address comparator pairs
// - Two counters, upper bits zero
// - Sequencer with four states
// - Low-power override supported, bit 24 reserved
// - Bus triggers supported
// - Trace identifier width is seven
// - Four external input selectors
// - External input count field reads 255, top bit zero
// - Least privileged level reads are undefined
// - Level one traps checked in order
// - Halted locked debug with level three trap undefines at levels one and two; level two order
`timescale 1ns/1ps
`default_nettype none
`include "trace_caps_defines.vh"
module trace_unit_capability_ids (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // Read request
  input  wire        rd_valid_in,
  input  wire [1:0]  op0_in,
  input  wire [2:0]  op1_in,
  input  wire [3:0]  crn_in,
  input  wire [3:0]  crm_in,
  input  wire [2:0]  op2_in,
  // Context
  input  wire [1:0]  level_in,
  input  wire        halted_in,
  input  wire        secure_debug_disabled_in,
  input  wire        level2_enabled_in,
  // Trap controls
  input  wire        level1_trace_trap_in,
  input  wire        level2_trace_trap_in,
  input  wire        level3_trace_trap_in,
  input  wire        fine_grained_trap_enable_in,
  input  wire        fine_grained_id_read_trap_in,
  // Answer
  output reg         rd_done_out,
  output reg  [63:0] rd_data_out,
  output reg         undefined_out,
  output reg         trap_out,
  output reg  [1:0]  trap_level_out,
  output reg  [5:0]  trap_class_out,
  output reg         no_match_out
);
  wire [63:0] base_word;
  wire [63:0] cmp_word;
  wire [63:0] res_word;
  wire [1:0]  verdict;
  wire [1:0]  target;
  reg  [63:0] sel_word;
  reg         sel_hit;
  wire        upper_hit;

  cap_word_builder words (
    .base_arch_out  (base_word),
    .comparator_out (cmp_word),
    .resource_out   (res_word)
  );

  access_checker access_u (
    .level_in                     (level_in),
    .halted_in                    (halted_in),
    .secure_debug_disabled_in     (secure_debug_disabled_in),
    .level2_enabled_in            (level2_enabled_in),
    .level1_trace_trap_in         (level1_trace_trap_in),
    .level2_trace_trap_in         (level2_trace_trap_in),
    .level3_trace_trap_in         (level3_trace_trap_in),
    .fine_grained_trap_enable_in  (fine_grained_trap_enable_in),
    .fine_grained_id_read_trap_in (fine_grained_id_read_trap_in),
    .result_out                   (verdict),
    .target_out                   (target)
  );

  // Shared selector fields, register chosen by second index
  assign upper_hit = (op0_in == `SEL_OP0) && (op1_in == `SEL_OP1) &&
                     (crn_in == `SEL_CRN) && (op2_in == `SEL_OP2);

  always @* begin
    sel_word = 64'h0;
    sel_hit  = 1'b0;
    if (upper_hit) begin
      case (crm_in)
        `CRM_BASE_ARCH: begin
          sel_word = base_word;
          sel_hit  = 1'b1;
        end
        `CRM_COMPARATOR: begin
          sel_word = cmp_word;
          sel_hit  = 1'b1;
        end
        `CRM_RESOURCE: begin
          sel_word = res_word;
          sel_hit  = 1'b1;
        end
        default: begin
          sel_hit  = 1'b0;
        end
      endcase
    end
  end

  // One-cycle registered answer; data only on a granted read
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_done_out    <= 1'b0;
      rd_data_out    <= 64'h0;
      undefined_out  <= 1'b0;
      trap_out       <= 1'b0;
      trap_level_out <= 2'h0;
      trap_class_out <= 6'h0;
      no_match_out   <= 1'b0;
    end else begin
      rd_done_out    <= rd_valid_in;
      rd_data_out    <= 64'h0;
      undefined_out  <= 1'b0;
      trap_out       <= 1'b0;
      trap_level_out <= 2'h0;
      trap_class_out <= 6'h0;
      no_match_out   <= 1'b0;
      if (rd_valid_in) begin
        if (!sel_hit) begin
          no_match_out <= 1'b1;
        end else if (verdict == `RES_UNDEF) begin
          undefined_out <= 1'b1;
        end else if (verdict == `RES_TRAP) begin
          trap_out       <= 1'b1;
          trap_level_out <= target;
          trap_class_out <= `TRAP_CLASS;
        end else begin
          rd_data_out <= sel_word;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### cap_ids_monitor.sv
// Checker for the capability identification bank
// Assumes it is bound onto trace_unit_capability_ids
`timescale 1ns/1ps
`default_nettype none
module cap_ids_monitor (
  input wire        clock_in,
  input wire        rst_n_in,
  input wire        rd_valid_in,
  input wire [1:0]  op0_in,
  input wire [2:0]  op1_in,
  input wire [3:0]  crn_in,
  input wire [3:0]  crm_in,
  input wire [2:0]  op2_in,
  input wire [1:0]  level_in,
  input wire        halted_in,
  input wire        secure_debug_disabled_in,
  input wire        level3_trace_trap_in,
  input wire        rd_done_out,
  input wire [63:0] rd_data_out,
  input wire        undefined_out,
  input wire        trap_out,
  input wire [1:0]  trap_level_out,
  input wire [5:0]  trap_class_out
);
  wire hit = rd_valid_in && op0_in == 2'h2 && op1_in == 3'h1 && crn_in == 4'h0 &&
             op2_in == 3'h7 && crm_in >= 4'hb && crm_in <= 4'hd;
  wire go3 = hit && level_in == 2'h3 && !level3_trace_trap_in;
  wire lock = halted_in && secure_debug_disabled_in && level3_trace_trap_in;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_done_follows: assert property (rd_valid_in |=> rd_done_out)
    else $error("no answer after request");
  a_idle_quiet: assert property (!rd_valid_in |=>
    !rd_done_out && !undefined_out && !trap_out && rd_data_out == 64'h0)
    else $error("output without request");
  a_upper_zero: assert property (rd_done_out |-> rd_data_out[63:32] == 32'h0)
    else $error("upper word not zero");
  a_base_word: assert property (go3 && crm_in == 4'hb |=>
    rd_data_out == 64'h0d7f0004) else $error("base word wrong");
  a_cmp_word: assert property (go3 && crm_in == 4'hc |=>
    rd_data_out == 64'h11170004) else $error("comparator word wrong");
  a_res_word: assert property (go3 && crm_in == 4'hd |=>
    rd_data_out == 64'h28c708ff) else $error("resource word wrong");
  a_least_undef: assert property (hit && level_in == 2'h0 |=> undefined_out && !trap_out)
    else $error("level zero read not undefined");
  a_trap_class: assert property (trap_out |-> trap_class_out == 6'h18 && trap_level_out != 2'h0)
    else $error("trap class or level wrong");
  a_lock_undef: assert property (hit && lock && (level_in == 2'h1 || level_in == 2'h2) |=>
    undefined_out) else $error("locked read not undefined");
  a_top_trap: assert property (hit && level_in == 2'h3 && level3_trace_trap_in |=>
    trap_out && trap_level_out == 2'h3) else $error("level three trap wrong");
endmodule
bind trace_unit_capability_ids cap_ids_monitor mon_u (.clock_in, .rst_n_in, .rd_valid_in,
  .op0_in, .op1_in, .crn_in, .crm_in, .op2_in, .level_in, .halted_in,
  .secure_debug_disabled_in, .level3_trace_trap_in, .rd_done_out, .rd_data_out,
  .undefined_out, .trap_out, .trap_level_out, .trap_class_out);
`default_nettype wire

// ### trace_unit_capability_ids_tb.sv
// Testbench for the capability identification bank
// Assumes the design files and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module trace_unit_capability_ids_tb;
  typedef struct packed {
    logic [1:0] lvl;
    logic [7:0] ctl;
    logic [3:0] crm;
    logic [1:0] kind;
    logic [1:0] tl;
  } row_t;
  logic clock_in = 0, rst_n_in = 0, rd_valid_in = 0, halted_in, secure_debug_disabled_in;
  logic level2_enabled_in, level1_trace_trap_in, level2_trace_trap_in, level3_trace_trap_in;
  logic fine_grained_trap_enable_in, fine_grained_id_read_trap_in;
  logic [1:0] op0_in = 0, level_in = 0, trap_level_out;
  logic [2:0] op1_in = 0, op2_in = 0;
  logic [3:0] crn_in = 0, crm_in = 0;
  logic rd_done_out, undefined_out, trap_out, no_match_out;
  logic [63:0] rd_data_out;
  logic [5:0] trap_class_out;
  int num_errors = 0, num_checks = 0;
  // Control bits: halted, debug lock, level2 on, traps 1 2 3, fine enable, fine id
  row_t rows [22] = '{'{2'h3,8'h00,4'hb,2'h0,2'h0}, '{2'h3,8'h00,4'hc,2'h0,2'h0},
    '{2'h3,8'h00,4'hd,2'h0,2'h0}, '{2'h0,8'h00,4'hb,2'h1,2'h0}, '{2'h0,8'h00,4'ha,2'h3,2'h0},
    '{2'h1,8'h10,4'hc,2'h2,2'h1}, '{2'h1,8'h28,4'hc,2'h2,2'h2}, '{2'h1,8'h08,4'hd,2'h0,2'h0},
    '{2'h1,8'h23,4'hb,2'h2,2'h2}, '{2'h1,8'h03,4'hb,2'h0,2'h0}, '{2'h1,8'h04,4'hd,2'h2,2'h3},
    '{2'h1,8'hc4,4'hb,2'h1,2'h0}, '{2'h1,8'hd4,4'hc,2'h1,2'h0}, '{2'h1,8'hc0,4'hd,2'h0,2'h0},
    '{2'h2,8'h0c,4'hc,2'h2,2'h2}, '{2'h2,8'h04,4'hc,2'h2,2'h3}, '{2'h2,8'hc4,4'hd,2'h1,2'h0},
    '{2'h2,8'h23,4'hb,2'h0,2'h0}, '{2'h3,8'h04,4'hb,2'h2,2'h3}, '{2'h3,8'hc4,4'hd,2'h2,2'h3},
    '{2'h3,8'h38,4'hc,2'h0,2'h0}, '{2'h3,8'h00,4'he,2'h3,2'h0}};
  trace_unit_capability_ids dut_u (.clock_in, .rst_n_in, .rd_valid_in, .op0_in, .op1_in,
    .crn_in, .crm_in, .op2_in, .level_in, .halted_in, .secure_debug_disabled_in,
    .level2_enabled_in, .level1_trace_trap_in, .level2_trace_trap_in, .level3_trace_trap_in,
    .fine_grained_trap_enable_in, .fine_grained_id_read_trap_in, .rd_done_out, .rd_data_out,
    .undefined_out, .trap_out, .trap_level_out, .trap_class_out, .no_match_out);
  always #5 clock_in = ~clock_in;
  function automatic logic [63:0] exp_word(input logic [3:0] crm);
    case (crm)
      4'hb: exp_word = 64'h000000000d7f0004;
      4'hc: exp_word = 64'h0000000011170004;
      4'hd: exp_word = 64'h0000000028c708ff;
      default: exp_word = 64'h0;
    endcase
  endfunction
  task automatic compare(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic drive(input row_t r, input logic [2:0] op2);
    {op0_in, op1_in, crn_in, op2_in, crm_in, level_in} = {2'h2, 3'h1, 4'h0, op2, r.crm, r.lvl};
    {halted_in, secure_debug_disabled_in, level2_enabled_in, level1_trace_trap_in,
     level2_trace_trap_in, level3_trace_trap_in, fine_grained_trap_enable_in,
     fine_grained_id_read_trap_in} = r.ctl;
    rd_valid_in = 1;
  endtask
  task automatic check_row(input row_t r);
    compare({rd_done_out, undefined_out, trap_out, no_match_out, trap_level_out, trap_class_out},
      {1'b1, r.kind == 2'h1, r.kind == 2'h2, r.kind == 2'h3, r.tl,
       (r.kind == 2'h2) ? 6'h18 : 6'h0}, "flags");
    compare(rd_data_out, (r.kind == 2'h0) ? exp_word(r.crm) : 64'h0, "data");
  endtask
  task automatic read_row(input row_t r, input logic [2:0] op2);
    drive(r, op2);
    @(posedge clock_in) #1;
    rd_valid_in = 0;
    check_row(r);
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    drive(rows[0], 3'h7);
    rd_valid_in = 0;
    repeat (8) @(posedge clock_in);
    #1 rst_n_in = 1;
    @(posedge clock_in) #1;
    foreach (rows[i]) read_row(rows[i], 3'h7);
    $display("Test table done");
    read_row('{2'h3, 8'h00, 4'hb, 2'h3, 2'h0}, 3'h6);
    $display("Test wrong selector done");
    drive(rows[1], 3'h7);
    @(posedge clock_in) #1;
    drive(rows[6], 3'h7);
    check_row(rows[1]);
    @(posedge clock_in) #1;
    rd_valid_in = 0;
    check_row(rows[6]);
    @(posedge clock_in) #1;
    compare({rd_done_out, trap_out, rd_data_out[31:0]}, 34'h0, "idle");
    $display("Test back to back done");
    read_row(rows[2], 3'h7);
    rst_n_in = 0;
    #2 compare({rd_done_out, no_match_out, rd_data_out[31:0]}, 34'h0, "reset");
    @(posedge clock_in) #1 rst_n_in = 1;
    @(posedge clock_in) #1;
    read_row(rows[2], 3'h7);
    $display("Test second reset done");
    give_verdict;
  end
  initial begin
    #(400 * 10);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict;
  end
endmodule
`default_nettype wire
